// [ifr_image_format.sv]
// ifr_image_format: skip, mirror control, region cut, layout and test
// image of the pixel stream. assumes sensor readout on ref_clk, which
// flips its own scan order and performs merging as told on readoutCtl.
//
// Overview of operation
// - array column count reads back as 3216, read-only.
// - array row count reads back as 2208, read-only.
// - max columns follow column merging and skipping, not region width or start.
// - max rows follow row merging and skipping, not region height or start.
// - each output line carries exactly the configured width of pixels.
// - each output frame carries exactly the configured height of lines.
// - region begins at the configured start column.
// - region begins at the configured start row.
// - column skip factor N keeps one pixel per N columns; 1 keeps all.
// - row skip factor N keeps one line per N rows; 1 keeps all.
// - merging applies only while both skip factors are 1.
// - skipping in a direction applies only while its merge factor is 1.
// - column mirror flips before the region; mosaic RG becomes GR.
// - row mirror flips before the region; mosaic RG becomes GB.
// - pixels leave in the selected sample layout.
// - bits per sample reads back per layout, from 8 to 24.
// - mosaic reads back its Bayer phase, or none for other layouts.
// - selector picks the generator; its pattern replaces sensor data.
// - digitisation depth is selectable; deeper means slower frames.
`timescale 1ns/10ps

module ifr_image_format #(
  parameter int FAC_W = ifr_pkg::FAC_W
) (
  input  wire logic                        ref_clk,
  input  wire logic                        resetn,
  input  wire logic [ifr_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [ifr_pkg::DATA_W-1:0]  regWdata,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output      logic [ifr_pkg::DATA_W-1:0]  regRdata,
  input  wire ifr_pkg::ifr_pix_in_t        pixIn,
  output      ifr_pkg::ifr_pix_out_t       pixOut,
  output      ifr_pkg::ifr_readout_t       readoutCtl
);

  logic [11:0]            width_q;
  logic [11:0]            height_q;
  logic [11:0]            colStart_q;
  logic [11:0]            rowStart_q;
  ifr_pkg::ifr_layout_t   layout_q;
  logic [FAC_W-1:0]       colSkip_q;
  logic [FAC_W-1:0]       rowSkip_q;
  logic [FAC_W-1:0]       colMerge_q;
  logic [FAC_W-1:0]       rowMerge_q;
  logic                   mirrorCols_q;
  logic                   mirrorRows_q;
  ifr_pkg::ifr_syn_sel_t  synSel_q;
  ifr_pkg::ifr_syn_kind_t synKindSensor_q;
  ifr_pkg::ifr_syn_kind_t synKindPipe_q;
  logic                   adcDepth_q;
  logic [11:0]            maxCols_q;
  logic [11:0]            maxRows_q;
  logic [ifr_pkg::DATA_W-1:0] rdata_q;
  ifr_pkg::ifr_cfg_t      shadow_q;
  ifr_pkg::ifr_cfg_t      liveCfg;
  ifr_pkg::ifr_cfg_t      cfg;
  logic [FAC_W-1:0]       colSkipEff;
  logic [FAC_W-1:0]       rowSkipEff;
  logic [FAC_W-1:0]       colMergeEff;
  logic [FAC_W-1:0]       rowMergeEff;
  logic [3:0]             colPh_q;
  logic [3:0]             rowPh_q;
  logic [11:0]            decCol_q;
  logic [11:0]            decRow_q;
  logic [3:0]             colPhNow;
  logic [3:0]             rowPhNow;
  logic [11:0]            decColNow;
  logic [11:0]            decRowNow;
  logic [12:0]            colEnd;
  logic [12:0]            rowEnd;
  logic                   keepCol;
  logic                   keepRow;
  logic                   inCols;
  logic                   inRows;
  logic                   keep;
  logic                   lastCol;
  logic                   lastRow;
  logic                   inFrame_q;
  logic [ifr_pkg::FRAME_CNT_W-1:0] frameCnt_q;
  logic [ifr_pkg::PIX_W-1:0] srcSample;
  logic [6:0]             bitsPerSample;
  ifr_pkg::ifr_mosaic_t   mosaic;
  ifr_pkg::ifr_pix_out_t  pixOut_q;
  ifr_pkg::ifr_readout_t  readout_q;

  // clamp a factor write to 1..MAX_FACTOR
  function automatic logic [FAC_W-1:0] clampFactor(
    input logic [ifr_pkg::DATA_W-1:0] v
  );
    logic [FAC_W-1:0] r;
    r = ifr_pkg::RST_FACTOR;
    if (v > ifr_pkg::DATA_W'(ifr_pkg::MAX_FACTOR))
      r = ifr_pkg::MAX_FACTOR;
    else if (v != '0)
      r = v[FAC_W-1:0];
    return r;
  endfunction

  // sample into the selected output layout
  function automatic logic [ifr_pkg::OUT_W-1:0] formatSample(
    input ifr_pkg::ifr_layout_t   lay,
    input logic [ifr_pkg::PIX_W-1:0] s
  );
    logic [ifr_pkg::OUT_W-1:0] r;
    r = '0;
    case (lay.family)
      ifr_pkg::FAM_MONO, ifr_pkg::FAM_BAYER:
        case (lay.depth)
          ifr_pkg::DEPTH_8:  r = {24'h000000, s[15:8]};
          ifr_pkg::DEPTH_10: r = {22'h000000, s[15:6]};
          ifr_pkg::DEPTH_12: r = {20'h00000, s[15:4]};
          default:           r = {16'h0000, s};
        endcase
      ifr_pkg::FAM_RGB, ifr_pkg::FAM_BGR:
        r = {8'h00, s[15:8], s[15:8], s[15:8]};
      ifr_pkg::FAM_YUV422:
        r = {16'h0000, 8'h80, s[15:8]};
      ifr_pkg::FAM_YUV444:
        r = {8'h00, 8'h80, 8'h80, s[15:8]};
      default:
        r = '0;
    endcase
    return r;
  endfunction

  // merge only without skipping, skipping only without merging
  always_comb
  begin
    if (colSkip_q == 4'h1 && rowSkip_q == 4'h1)
    begin
      colMergeEff = colMerge_q;
      rowMergeEff = rowMerge_q;
    end
    else
    begin
      colMergeEff = ifr_pkg::RST_FACTOR;
      rowMergeEff = ifr_pkg::RST_FACTOR;
    end
    colSkipEff = (colMerge_q == 4'h1) ? colSkip_q
                                      : ifr_pkg::RST_FACTOR;
    rowSkipEff = (rowMerge_q == 4'h1) ? rowSkip_q
                                      : ifr_pkg::RST_FACTOR;
  end

  // register writes
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      width_q         <= ifr_pkg::RST_WIDTH;
      height_q        <= ifr_pkg::RST_HEIGHT;
      colStart_q      <= '0;
      rowStart_q      <= '0;
      layout_q        <= '0;
      colSkip_q       <= ifr_pkg::RST_FACTOR;
      rowSkip_q       <= ifr_pkg::RST_FACTOR;
      colMerge_q      <= ifr_pkg::RST_FACTOR;
      rowMerge_q      <= ifr_pkg::RST_FACTOR;
      mirrorCols_q    <= 1'b0;
      mirrorRows_q    <= 1'b0;
      synSel_q        <= ifr_pkg::SYN_SEL_SENSOR;
      synKindSensor_q <= ifr_pkg::SYN_OFF;
      synKindPipe_q   <= ifr_pkg::SYN_OFF;
      adcDepth_q      <= 1'b0;
    end
    else if (regWr)
    begin
      case (regAddr)
        ifr_pkg::OFS_WIDTH:     width_q    <= regWdata[11:0];
        ifr_pkg::OFS_HEIGHT:    height_q   <= regWdata[11:0];
        ifr_pkg::OFS_COL_START: colStart_q <= regWdata[11:0];
        ifr_pkg::OFS_ROW_START: rowStart_q <= regWdata[11:0];
        ifr_pkg::OFS_LAYOUT:
          if (regWdata[6:4] <= 3'(ifr_pkg::FAM_YUV444))
            layout_q <= ifr_pkg::ifr_layout_t'(regWdata[6:0]);
        ifr_pkg::OFS_COL_SKIP:  colSkip_q  <= clampFactor(regWdata);
        ifr_pkg::OFS_ROW_SKIP:  rowSkip_q  <= clampFactor(regWdata);
        ifr_pkg::OFS_COL_MERGE: colMerge_q <= clampFactor(regWdata);
        ifr_pkg::OFS_ROW_MERGE: rowMerge_q <= clampFactor(regWdata);
        ifr_pkg::OFS_MIRROR:
        begin
          mirrorCols_q <= regWdata[ifr_pkg::MIRROR_COLS_BIT];
          mirrorRows_q <= regWdata[ifr_pkg::MIRROR_ROWS_BIT];
        end
        ifr_pkg::OFS_SYN_SELECT:
          synSel_q <= ifr_pkg::ifr_syn_sel_t'(regWdata[0]);
        ifr_pkg::OFS_SYN_KIND:
          if (regWdata[1:0] != 2'h3)
          begin
            if (synSel_q == ifr_pkg::SYN_SEL_SENSOR)
              synKindSensor_q <= ifr_pkg::ifr_syn_kind_t'(regWdata[1:0]);
            else
              synKindPipe_q <= ifr_pkg::ifr_syn_kind_t'(regWdata[1:0]);
          end
        ifr_pkg::OFS_ADC_DEPTH: adcDepth_q <= regWdata[0];
        default: ;
      endcase
    end
  end

  // maximum image size after merging and skipping
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      maxCols_q <= ifr_pkg::ARRAY_COLUMNS;
      maxRows_q <= ifr_pkg::ARRAY_ROWS;
    end
    else
    begin
      maxCols_q <= 12'(ifr_pkg::ARRAY_COLUMNS
                   / (8'(colMergeEff) * 8'(colSkipEff)));
      maxRows_q <= 12'(ifr_pkg::ARRAY_ROWS
                   / (8'(rowMergeEff) * 8'(rowSkipEff)));
    end
  end

  // readout controls: merge factors, scan direction, depth, sensor pattern
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      readout_q <= '{colMerge: ifr_pkg::RST_FACTOR,
                     rowMerge: ifr_pkg::RST_FACTOR,
                     colReverse: 1'b0, rowReverse: 1'b0,
                     adcDepth: 1'b0, synKind: ifr_pkg::SYN_OFF};
    else
    begin
      readout_q.colMerge   <= colMergeEff;
      readout_q.rowMerge   <= rowMergeEff;
      readout_q.colReverse <= mirrorCols_q;
      readout_q.rowReverse <= mirrorRows_q;
      readout_q.adcDepth   <= adcDepth_q;
      readout_q.synKind    <= synKindSensor_q;
    end
  end

  // frame geometry held steady from start of frame
  always_comb
  begin
    liveCfg = '{width: width_q, height: height_q,
                colStart: colStart_q, rowStart: rowStart_q,
                colSkip: colSkipEff, rowSkip: rowSkipEff,
                layout: layout_q, synKind: synKindPipe_q};
    cfg = (pixIn.valid && pixIn.sof) ? liveCfg : shadow_q;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      shadow_q <= '{width: ifr_pkg::RST_WIDTH,
                    height: ifr_pkg::RST_HEIGHT,
                    colStart: 12'h000, rowStart: 12'h000,
                    colSkip: ifr_pkg::RST_FACTOR,
                    rowSkip: ifr_pkg::RST_FACTOR,
                    layout: '0, synKind: ifr_pkg::SYN_OFF};
    else if (pixIn.valid && pixIn.sof)
      shadow_q <= liveCfg;
  end

  // position of the incoming pixel in skipped coordinates
  always_comb
  begin
    colPhNow  = pixIn.sof ? 4'h0 : colPh_q;
    rowPhNow  = pixIn.sof ? 4'h0 : rowPh_q;
    decColNow = pixIn.sof ? 12'h000 : decCol_q;
    decRowNow = pixIn.sof ? 12'h000 : decRow_q;
    keepCol   = (colPhNow == 4'h0);
    keepRow   = (rowPhNow == 4'h0);
    colEnd    = {1'b0, cfg.colStart} + {1'b0, cfg.width};
    rowEnd    = {1'b0, cfg.rowStart} + {1'b0, cfg.height};
    inCols    = (decColNow >= cfg.colStart)
                && ({1'b0, decColNow} < colEnd);
    inRows    = (decRowNow >= cfg.rowStart)
                && ({1'b0, decRowNow} < rowEnd);
    keep      = pixIn.valid && keepCol && keepRow && inCols && inRows;
    lastCol   = ({1'b0, decColNow} == colEnd - 13'h0001);
    lastRow   = ({1'b0, decRowNow} == rowEnd - 13'h0001);
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      colPh_q  <= '0;
      decCol_q <= '0;
    end
    else if (pixIn.valid)
    begin
      if (pixIn.eol)
      begin
        colPh_q  <= '0;
        decCol_q <= '0;
      end
      else
      begin
        colPh_q  <= (colPhNow == cfg.colSkip - 4'h1) ? 4'h0
                                                      : colPhNow + 4'h1;
        decCol_q <= decColNow + {11'h000, keepCol};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rowPh_q  <= '0;
      decRow_q <= '0;
    end
    else if (pixIn.valid && pixIn.eol)
    begin
      rowPh_q  <= (rowPhNow == cfg.rowSkip - 4'h1) ? 4'h0
                                                    : rowPhNow + 4'h1;
      decRow_q <= decRowNow + {11'h000, keepRow};
    end
    else if (pixIn.valid && pixIn.sof)
    begin
      rowPh_q  <= '0;
      decRow_q <= '0;
    end
  end

  // pattern source replaces sensor samples when enabled
  always_comb
  begin
    case (cfg.synKind)
      ifr_pkg::SYN_INCREMENT:
        srcSample = {decColNow + decRowNow, 4'h0};
      ifr_pkg::SYN_BARS:
        srcSample = {decColNow[8:1], 8'h00};
      default:
        srcSample = pixIn.data;
    endcase
  end

  // formatted output stream with frame and line marks
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      pixOut_q <= '0;
    else
    begin
      pixOut_q.valid <= keep;
      pixOut_q.sof   <= keep && decColNow == cfg.colStart
                        && decRowNow == cfg.rowStart;
      pixOut_q.eol   <= keep && lastCol;
      pixOut_q.eof   <= keep && lastCol && lastRow;
      if (keep)
        pixOut_q.data <= formatSample(cfg.layout, srcSample);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      inFrame_q  <= 1'b0;
      frameCnt_q <= '0;
    end
    else if (keep && lastCol && lastRow)
    begin
      inFrame_q  <= 1'b0;
      frameCnt_q <= frameCnt_q + 16'h0001;
    end
    else if (pixIn.valid && pixIn.sof)
      inFrame_q <= 1'b1;
  end

  // bits per sample and mosaic after mirroring
  always_comb
  begin
    case (layout_q.family)
      ifr_pkg::FAM_MONO, ifr_pkg::FAM_BAYER:
        case (layout_q.depth)
          ifr_pkg::DEPTH_8:  bitsPerSample = 7'd8;
          ifr_pkg::DEPTH_10: bitsPerSample = 7'd10;
          ifr_pkg::DEPTH_12: bitsPerSample = 7'd12;
          default:           bitsPerSample = 7'd16;
        endcase
      ifr_pkg::FAM_YUV422: bitsPerSample = 7'd16;
      default:             bitsPerSample = 7'd24;
    endcase
    mosaic = ifr_pkg::MOS_NONE;
    if (layout_q.family == ifr_pkg::FAM_BAYER)
      case (layout_q.phase ^ {mirrorRows_q, mirrorCols_q})
        ifr_pkg::PH_RG: mosaic = ifr_pkg::MOS_RG;
        ifr_pkg::PH_GR: mosaic = ifr_pkg::MOS_GR;
        ifr_pkg::PH_GB: mosaic = ifr_pkg::MOS_GB;
        default:        mosaic = ifr_pkg::MOS_BG;
      endcase
  end

  // read data one cycle after the strobe
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= '0;
    else if (regRd)
    begin
      rdata_q <= '0;
      case (regAddr)
        ifr_pkg::OFS_ARRAY_COLS:
          rdata_q[11:0] <= ifr_pkg::ARRAY_COLUMNS;
        ifr_pkg::OFS_ARRAY_ROWS:
          rdata_q[11:0] <= ifr_pkg::ARRAY_ROWS;
        ifr_pkg::OFS_MAX_COLS:  rdata_q[11:0] <= maxCols_q;
        ifr_pkg::OFS_MAX_ROWS:  rdata_q[11:0] <= maxRows_q;
        ifr_pkg::OFS_WIDTH:     rdata_q[11:0] <= width_q;
        ifr_pkg::OFS_HEIGHT:    rdata_q[11:0] <= height_q;
        ifr_pkg::OFS_COL_START: rdata_q[11:0] <= colStart_q;
        ifr_pkg::OFS_ROW_START: rdata_q[11:0] <= rowStart_q;
        ifr_pkg::OFS_LAYOUT:    rdata_q[6:0]  <= layout_q;
        ifr_pkg::OFS_BPS:       rdata_q[6:0]  <= bitsPerSample;
        ifr_pkg::OFS_MOSAIC:    rdata_q[2:0]  <= mosaic;
        ifr_pkg::OFS_COL_SKIP:  rdata_q[3:0]  <= colSkip_q;
        ifr_pkg::OFS_ROW_SKIP:  rdata_q[3:0]  <= rowSkip_q;
        ifr_pkg::OFS_COL_MERGE: rdata_q[3:0]  <= colMerge_q;
        ifr_pkg::OFS_ROW_MERGE: rdata_q[3:0]  <= rowMerge_q;
        ifr_pkg::OFS_MIRROR:    rdata_q[1:0]  <= {mirrorRows_q, mirrorCols_q};
        ifr_pkg::OFS_SYN_SELECT: rdata_q[0]   <= synSel_q;
        ifr_pkg::OFS_SYN_KIND:
          rdata_q[1:0] <= (synSel_q == ifr_pkg::SYN_SEL_SENSOR)
                          ? synKindSensor_q : synKindPipe_q;
        ifr_pkg::OFS_ADC_DEPTH: rdata_q[0]    <= adcDepth_q;
        ifr_pkg::OFS_STATUS:
        begin
          rdata_q[ifr_pkg::STATUS_BUSY_BIT] <= inFrame_q;
          rdata_q[31:ifr_pkg::STATUS_CNT_LSB] <= frameCnt_q;
        end
        default: rdata_q <= '0;
      endcase
    end
  end

  assign regRdata   = rdata_q;
  assign pixOut     = pixOut_q;
  assign readoutCtl = readout_q;

endmodule // ifr_image_format

// [ifr_pkg.sv]
// ifr_pkg: constants, register map and carrier types of the image format
// stage; assumes a single pixel clock and 16-bit left-justified samples.
package ifr_pkg;

  localparam int          DIM_W         = 12;
  localparam int          FAC_W         = 4;
  localparam int          PIX_W         = 16;
  localparam int          OUT_W         = 32;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          FRAME_CNT_W   = 16;

  // fixed array geometry
  localparam logic [11:0] ARRAY_COLUMNS = 12'd3216;
  localparam logic [11:0] ARRAY_ROWS    = 12'd2208;

  // register byte offsets
  localparam logic [7:0] OFS_ARRAY_COLS   = 8'h00;
  localparam logic [7:0] OFS_ARRAY_ROWS   = 8'h04;
  localparam logic [7:0] OFS_MAX_COLS     = 8'h08;
  localparam logic [7:0] OFS_MAX_ROWS     = 8'h0c;
  localparam logic [7:0] OFS_WIDTH        = 8'h10;
  localparam logic [7:0] OFS_HEIGHT       = 8'h14;
  localparam logic [7:0] OFS_COL_START    = 8'h18;
  localparam logic [7:0] OFS_ROW_START    = 8'h1c;
  localparam logic [7:0] OFS_LAYOUT       = 8'h20;
  localparam logic [7:0] OFS_BPS          = 8'h24;
  localparam logic [7:0] OFS_MOSAIC       = 8'h28;
  localparam logic [7:0] OFS_COL_SKIP     = 8'h2c;
  localparam logic [7:0] OFS_ROW_SKIP     = 8'h30;
  localparam logic [7:0] OFS_COL_MERGE    = 8'h34;
  localparam logic [7:0] OFS_ROW_MERGE    = 8'h38;
  localparam logic [7:0] OFS_MIRROR       = 8'h3c;
  localparam logic [7:0] OFS_SYN_SELECT   = 8'h40;
  localparam logic [7:0] OFS_SYN_KIND     = 8'h44;
  localparam logic [7:0] OFS_ADC_DEPTH    = 8'h48;
  localparam logic [7:0] OFS_STATUS       = 8'h4c;

  // field positions
  localparam int MIRROR_COLS_BIT = 0;
  localparam int MIRROR_ROWS_BIT = 1;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_CNT_LSB  = 16;

  // reset values
  localparam logic [11:0] RST_WIDTH  = 12'd3216;
  localparam logic [11:0] RST_HEIGHT = 12'd2208;
  localparam logic [3:0]  RST_FACTOR = 4'h1;
  localparam logic [3:0]  MAX_FACTOR = 4'h8;

  typedef enum logic [2:0] {
    FAM_MONO, FAM_BAYER, FAM_RGB, FAM_BGR, FAM_YUV422, FAM_YUV444
  } ifr_family_t;

  typedef enum logic [1:0] {DEPTH_8, DEPTH_10, DEPTH_12, DEPTH_16}
    ifr_depth_t;

  // phase bit0: column parity swap, bit1: row parity swap
  typedef enum logic [1:0] {PH_RG, PH_GR, PH_GB, PH_BG} ifr_phase_t;

  typedef enum logic [2:0] {
    MOS_NONE, MOS_RG, MOS_GB, MOS_GR, MOS_BG
  } ifr_mosaic_t;

  typedef enum logic [1:0] {SYN_OFF, SYN_INCREMENT, SYN_BARS}
    ifr_syn_kind_t;

  typedef enum logic {SYN_SEL_SENSOR, SYN_SEL_PIPELINE} ifr_syn_sel_t;

  typedef struct packed {
    ifr_family_t family;
    ifr_depth_t  depth;
    ifr_phase_t  phase;
  } ifr_layout_t;

  typedef struct packed {
    logic [11:0]   width;
    logic [11:0]   height;
    logic [11:0]   colStart;
    logic [11:0]   rowStart;
    logic [3:0]    colSkip;
    logic [3:0]    rowSkip;
    ifr_layout_t   layout;
    ifr_syn_kind_t synKind;
  } ifr_cfg_t;

  typedef struct packed {
    logic             valid;
    logic             sof;
    logic             eol;
    logic [PIX_W-1:0] data;
  } ifr_pix_in_t;

  typedef struct packed {
    logic             valid;
    logic             sof;
    logic             eol;
    logic             eof;
    logic [OUT_W-1:0] data;
  } ifr_pix_out_t;

  typedef struct packed {
    logic [3:0]    colMerge;
    logic [3:0]    rowMerge;
    logic          colReverse;
    logic          rowReverse;
    logic          adcDepth;
    ifr_syn_kind_t synKind;
  } ifr_readout_t;

endpackage

// [ifr_image_format_props.sv]
// ifr_image_format_props: port checks of the image format stage
// assumes bound to ifr_image_format, software keeps region inside frame
`timescale 1ns/10ps
module ifr_image_format_props (
  input wire logic                  ref_clk,
  input wire logic                  resetn,
  input wire logic [7:0]            regAddr,
  input wire logic [31:0]           regWdata,
  input wire logic                  regWr,
  input wire logic                  regRd,
  input wire logic [31:0]           regRdata,
  input wire ifr_pkg::ifr_pix_in_t  pixIn,
  input wire ifr_pkg::ifr_pix_out_t pixOut,
  input wire ifr_pkg::ifr_readout_t readoutCtl
);
  logic [1:0]  mirQ;
  logic        cs1;
  logic        rs1;
  logic        mw;
  logic [11:0] wLive, hLive, wSof, hSof, colN, rowN;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  assign mw = regWr && regAddr == 8'h3c;
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      mirQ  <= 2'h0;
      cs1   <= 1'b1;
      rs1   <= 1'b1;
      wLive <= 12'hc90;
      hLive <= 12'h8a0;
      wSof  <= 12'hc90;
      hSof  <= 12'h8a0;
      colN  <= 12'h0;
      rowN  <= 12'h0;
    end
    else
    begin
      if (mw)
        mirQ <= regWdata[1:0];
      if (regWr && regAddr == 8'h2c)
        cs1 <= regWdata <= 32'h1;
      if (regWr && regAddr == 8'h30)
        rs1 <= regWdata <= 32'h1;
      if (regWr && regAddr == 8'h10)
        wLive <= regWdata[11:0];
      if (regWr && regAddr == 8'h14)
        hLive <= regWdata[11:0];
      if (pixIn.valid && pixIn.sof)
      begin
        wSof <= wLive;
        hSof <= hLive;
      end
      if (pixOut.valid)
        colN <= pixOut.eol ? 12'h0 : colN + 12'h1;
      if (pixOut.valid && pixOut.eol)
        rowN <= pixOut.eof ? 12'h0 : rowN + 12'h1;
    end
  AST_RD_COLS: assert property (
    regRd && regAddr == 8'h00 |=> regRdata == 32'hc90)
    else $error("array columns read wrong");
  AST_RD_ROWS: assert property (
    regRd && regAddr == 8'h04 |=> regRdata == 32'h8a0)
    else $error("array rows read wrong");
  AST_OUT_NEEDS_IN: assert property (
    pixOut.valid |-> $past(pixIn.valid))
    else $error("output pixel without input pixel");
  AST_EOF_WITH_EOL: assert property (
    pixOut.valid && pixOut.eof |-> pixOut.eol)
    else $error("frame end off a line end");
  AST_LINE_WIDTH: assert property (
    pixOut.valid && pixOut.eol |-> colN + 12'h1 == wSof)
    else $error("line length differs from width");
  AST_FRAME_HEIGHT: assert property (
    pixOut.valid && pixOut.eof |-> rowN + 12'h1 == hSof)
    else $error("line count differs from height");
  AST_MERGE_OFF: assert property (
    !(cs1 && rs1) ##1 !(cs1 && rs1) |->
      readoutCtl.colMerge == 4'h1 && readoutCtl.rowMerge == 4'h1)
    else $error("merging active while skipping");
  AST_MIRROR_FWD: assert property (
    !mw [*2] |-> {readoutCtl.rowReverse, readoutCtl.colReverse} == mirQ)
    else $error("scan direction differs from mirror setting");
  AST_SOF_FIRST: assert property (
    pixOut.valid |-> pixOut.sof == (colN == 12'h0 && rowN == 12'h0))
    else $error("frame start mark misplaced");
  cover property (pixOut.valid && pixOut.eof);
  cover property (pixOut.valid && pixOut.sof);
  cover property (regRd && regAddr == 8'h28);
  cover property (readoutCtl.colReverse && readoutCtl.rowReverse);
endmodule // ifr_image_format_props

bind ifr_image_format ifr_image_format_props ifr_image_format_props_inst (
  .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .pixIn(pixIn), .pixOut(pixOut),
  .readoutCtl(readoutCtl));

// [ifr_host_sink.sv]
// ifr_host_sink: host end of the formatted pixel stream
// assumes one pixel per valid cycle and no back-pressure
`timescale 1ns/10ps
module ifr_host_sink (
  input wire logic                  ref_clk,
  input wire logic                  resetn,
  input wire ifr_pkg::ifr_pix_out_t pixOut
);
  logic [31:0] got [0:63];
  int          gotN;
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      gotN <= 0;
    else if (pixOut.valid)
    begin
      got[gotN % 64] <= pixOut.data;
      gotN           <= gotN + 1;
    end
endmodule // ifr_host_sink

// [tb.sv]
// tb: register and pixel stream scenarios of the image format stage
// assumes ifr_host_sink collects output pixels, checker bound separately
`timescale 1ns/10ps
module tb;
  logic                  ref_clk;
  logic                  resetn;
  logic [7:0]            regAddr;
  logic [31:0]           regWdata;
  logic                  regWr;
  logic                  regRd;
  logic [31:0]           regRdata;
  ifr_pkg::ifr_pix_in_t  pixIn;
  ifr_pkg::ifr_pix_out_t pixOut;
  ifr_pkg::ifr_readout_t readoutCtl;
  int                    error_cnt = 0;
  int                    n_tests = 0;
  int                    cyc = 0;

  ifr_image_format ifr_image_format_inst (.ref_clk(ref_clk),
    .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pixIn(pixIn),
    .pixOut(pixOut), .readoutCtl(readoutCtl));
  ifr_host_sink ifr_host_sink_inst (.ref_clk(ref_clk), .resetn(resetn),
    .pixOut(pixOut));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic check(input string n, input logic [31:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input string n, input logic [7:0] a, input int e);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 check(n, regRdata, e);
    @(posedge ref_clk);
  endtask

  task automatic frame();
    for (int r = 0; r < 6; r++)
      for (int c = 0; c < 8; c++)
      begin
        pixIn <= '{1'b1, r == 0 && c == 0, c == 7, {r[7:0], c[7:0]}};
        @(posedge ref_clk);
      end
    pixIn <= '0;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic roi(input int w, h, cs, rs, sk, pat);
    int b, cc, rr;
    wr(8'h10, w);
    wr(8'h14, h);
    wr(8'h18, cs);
    wr(8'h1c, rs);
    wr(8'h2c, sk);
    wr(8'h30, sk);
    wr(8'h44, pat);
    b = ifr_host_sink_inst.gotN;
    frame();
    check("count", ifr_host_sink_inst.gotN - b, w * h);
    for (int i = 0; i < w * h; i++)
    begin
      cc = (cs + i % w) * sk;
      rr = (rs + i / w) * sk;
      check("pixel", ifr_host_sink_inst.got[(b + i) % 64], pat == 1 ?
        (cc + rr) << 4 : pat == 2 ? (cc >> 1) << 8 : rr * 256 + cc);
    end
  endtask

  task automatic t_regs();
    rd("cols", 8'h00, 3216);
    rd("rows", 8'h04, 2208);
    wr(8'h00, 5);
    rd("cols ro", 8'h00, 3216);
    rd("unmapped", 8'h80, 0);
    rd("width", 8'h10, 3216);
    wr(8'h10, 8);
    wr(8'h18, 4);
    rd("max cols", 8'h08, 3216);
    wr(8'h34, 2);
    wr(8'h38, 2);
    rd("max cols", 8'h08, 1608);
    rd("max rows", 8'h0c, 1104);
    check("merge", readoutCtl.colMerge, 2);
    wr(8'h2c, 2);
    rd("height", 8'h14, 2208);
    check("merge", readoutCtl.colMerge, 1);
    wr(8'h48, 1);
    rd("depth", 8'h48, 1);
    check("adc", readoutCtl.adcDepth, 1);
    wr(8'h2c, 9);
    rd("skip clamp", 8'h2c, 8);
    wr(8'h2c, 0);
    rd("skip zero", 8'h2c, 1);
    wr(8'h34, 1);
    wr(8'h38, 1);
  endtask

  task automatic t_format();
    int mt[4] = '{1, 3, 2, 4};
    int bt[4] = '{8, 10, 12, 16};
    for (int m = 0; m < 4; m++)
      for (int p = 0; p < 4; p++)
      begin
        wr(8'h20, 32'h10 + p);
        wr(8'h3c, m);
        rd("mosaic", 8'h28, mt[p ^ m]);
        check("reverse", {readoutCtl.rowReverse, readoutCtl.colReverse},
          m);
        wr(8'h20, 32'h10 + 4 * p);
        rd("bits", 8'h24, bt[p]);
      end
    wr(8'h3c, 0);
    wr(8'h20, 32'h20);
    rd("rgb bits", 8'h24, 24);
    rd("rgb mosaic", 8'h28, 0);
    wr(8'h20, 32'h40);
    rd("yuv bits", 8'h24, 16);
    wr(8'h20, 32'h70);
    rd("layout kept", 8'h20, 32'h40);
  endtask

  task automatic t_roi();
    wr(8'h20, 32'h0c);
    roi(3, 2, 2, 1, 1, 0);
    roi(3, 2, 1, 0, 2, 0);
    wr(8'h40, 1);
    roi(8, 6, 0, 0, 1, 1);
    roi(8, 6, 0, 0, 1, 2);
    wr(8'h40, 0);
    wr(8'h44, 2);
    rd("kind", 8'h44, 2);
    check("sensor kind", readoutCtl.synKind, 2);
    wr(8'h44, 3);
    rd("kind kept", 8'h44, 2);
    rd("status", 8'h4c, 32'h00040000);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  initial
  begin
    resetn   = 1'b0;
    regAddr  = 8'h00;
    regWdata = 32'h0;
    regWr    = 1'b0;
    regRd    = 1'b0;
    pixIn    = '0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_format();
    t_roi();
    end_of_test();
  end
endmodule // tb
